// [common/tcta_mem_if.sv]
/*
 * Port bundle between the test logic and the cache line store.
 * Assumes read data appear one clock after the address.
 */
`timescale 1ns/1ps
interface tcta_mem_if;
    logic we;
    logic [7:0] addr;
    logic [58:0] wdata;
    logic [58:0] rdata;
    modport ctrl (output we, output addr, output wdata, input rdata);
    modport mem (input we, input addr, input wdata, output rdata);
endinterface

// [common/tcta_pkg.sv]
/*
 * Constants, register map and types for the translation buffer and cache
 * test access block.
 * Assumes a 32-bit AXI4-Lite register bus and one clock domain.
 */
// Behaviour
// [R1] Translation buffer has four sets of eight entries each.
// [R2] Entry holds 20-bit linear tag, valid, three attributes, 20-bit page.
// [R3] Lookup and write tags come from command register address and fields.
// [R4] Command bit 0: zero writes an entry, one performs a lookup.
// [R5] Lookup uses bits 31-12; only a single match updates the registers.
// [R6] Test write allocates an entry and stores the data register page.
// [R7] Command bit 11 validates the written entry, or invalidates it.
// [R8] Attribute pairs sit at bits 10-9, 8-7 and 6-5.
// [R9] Pair 00 never matches, 01 zero, 10 one, 11 both; write sets.
// [R10] Data bits 31-12 return the page on lookup and supply it on write.
// [R11] Data bits 11 and 10 hold cache-disable and write-through.
// [R12] Data bits 9-7 return replacement bits before lookup; write ignores.
// [R13] Data bit 4 reads one on hit and zero on miss.
// [R14] On write, bit 4 one uses chosen set, zero uses pseudo-LRU.
// [R15] Data bits 3-2 report hit set, and choose the set on write.
// [R16] Cache has two sets of 128 lines reachable by test access.
// [R17] Cache line holds 23-bit tag, 32 data bits, four byte valids.
// [R18] Cache test read returns data, valid bits and replacement bit.
// [R19] Cache test write stores the data register into set and line.
// [R20] Software sets valid bits before writing data into a line.
// [R21] Control 00 nothing, 01 write, 10 read, 11 invalidate all.
// [R22] Control bits 10-4 choose the line, bit 2 the set.
// [R23] Command write starts the operation; results are ready before reads.
package tcta_pkg;
    localparam int ADDR_W = 5;
    localparam logic [ADDR_W-1:0] OFS_CMD = 5'h00;
    localparam logic [ADDR_W-1:0] OFS_DATA = 5'h04;
    localparam logic [ADDR_W-1:0] OFS_CDATA = 5'h08;
    localparam logic [ADDR_W-1:0] OFS_CTAG = 5'h0c;
    localparam logic [ADDR_W-1:0] OFS_CCTL = 5'h10;
    localparam logic [31:0] CMD_MASK = 32'hffffffe1;
    localparam logic [31:0] DATA_MASK = 32'hffffff9c;
    localparam logic [31:0] CTAG_MASK = 32'hfffffef8;
    localparam logic [31:0] CCTL_MASK = 32'h000007f7;
    localparam logic [31:0] REG_RESET = 32'h00000000;
    localparam int SETS = 4;
    localparam int ENTRIES = 8;
    localparam int CMD_OP = 0;
    localparam int CMD_V = 11;
    localparam int CMD_D = 9;
    localparam int CMD_U = 7;
    localparam int CMD_RW = 5;
    localparam int DAT_PCD = 11;
    localparam int DAT_PWT = 10;
    localparam int DAT_LRU = 7;
    localparam int DAT_HIT = 4;
    localparam int DAT_SET = 2;
    localparam int CTAG_LRU = 7;
    localparam int CTAG_VAL = 3;
    localparam int CTAG_TAG = 9;
    localparam int CCTL_LINE = 4;
    localparam int CCTL_SET = 2;
    localparam int CLINES = 128;
    localparam int CMEM_AW = 8;
    localparam int CMEM_W = 59;
    localparam logic [1:0] COP_NONE = 2'b00;
    localparam logic [1:0] COP_WRITE = 2'b01;
    localparam logic [1:0] COP_READ = 2'b10;
    localparam logic [1:0] COP_FLUSH = 2'b11;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
    typedef enum logic [5:0] {
        ST_IDLE = 6'b000001,
        ST_TLB = 6'b000010,
        ST_CWRITE = 6'b000100,
        ST_CREAD = 6'b001000,
        ST_CCAP = 6'b010000,
        ST_FLUSH = 6'b100000
    } tcta_state_t;
    typedef struct packed {
        logic valid;
        logic [19:0] tag;
        logic dirty;
        logic user;
        logic rw;
        logic [19:0] page;
        logic page_cache_disable;
        logic page_write_through;
    } tcta_entry_t;
endpackage

// [src/tcta_attr_match.sv]
/*
 * Compares one stored attribute bit against a value and complement pair.
 * Assumes the pair comes straight from the command register.
 */
`timescale 1ns/1ps
module tcta_attr_match (
    // Pair and stored bit.
    input wire logic [1:0] pair,
    input wire logic stored,
    // Result.
    output logic match
);
    always_comb begin
        case (pair)
            2'b01: match = ~stored; // R9
            2'b10: match = stored; // R9
            2'b11: match = 1'b1; // R9
            default: match = 1'b0; // R9
        endcase
    end
endmodule // tcta_attr_match

// [src/tcta_cache_mem.sv]
/*
 * Line store of the cache, both sets, with registered read data.
 * Assumes one access per clock from the test logic.
 */
`timescale 1ns/1ps
module tcta_cache_mem (
    // Clock.
    input wire logic aclk,
    // Access port.
    tcta_mem_if.mem port
);
    import tcta_pkg::*;
    logic [CMEM_W-1:0] store [0:(1<<CMEM_AW)-1]; // R16 R17
    always_ff @(posedge aclk) begin
        if (port.we) begin
            store[port.addr] <= port.wdata;
        end
        port.rdata <= store[port.addr];
    end
endmodule // tcta_cache_mem

// [src/tcta_top.sv]
/*
 * Test access for the translation buffer and the cache, behind an
 * AXI4-Lite slave. Holds the translation buffer itself.
 * Assumes a single clock and a master with one access of each kind open.
 */
`timescale 1ns/1ps
module tcta_top (
    // Clock and reset.
    input wire logic aclk,
    input wire logic aresetn,
    // Write address.
    input wire logic [tcta_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // Write data.
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // Write response.
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // Read address.
    input wire logic [tcta_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // Read data.
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    import tcta_pkg::*;

    typedef struct packed {
        tcta_state_t state;
        logic aw_held;
        logic [ADDR_W-1:0] aw_addr;
        logic w_held;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
        logic [31:0] cmd;
        logic [31:0] data;
        logic [31:0] cdata;
        logic [31:0] ctag;
        logic [31:0] cctl;
        logic [CLINES-1:0] clru;
        tcta_entry_t [SETS-1:0][ENTRIES-1:0] tlb; // R1 R2
        logic [ENTRIES-1:0][2:0] plru;
        logic mwe;
        logic [CMEM_AW-1:0] maddr;
        logic [CMEM_W-1:0] mwdata;
    } tcta_regs_t;

    tcta_regs_t st;
    tcta_regs_t next_st;
    tcta_mem_if mbus ();

    logic [2:0] idx;
    logic [SETS-1:0] way_hit;
    logic [SETS-1:0] m_d;
    logic [SETS-1:0] m_u;
    logic [SETS-1:0] m_rw;

    assign idx = st.cmd[14:12];

    // Attribute comparison for each way of the indexed entry row.
    genvar g;
    generate
        for (g = 0; g < SETS; g = g + 1) begin : g_way
            tcta_attr_match u_d (
                .pair(st.cmd[CMD_D+1:CMD_D]),
                .stored(st.tlb[g][idx].dirty),
                .match(m_d[g])
            );
            tcta_attr_match u_u (
                .pair(st.cmd[CMD_U+1:CMD_U]),
                .stored(st.tlb[g][idx].user),
                .match(m_u[g])
            );
            tcta_attr_match u_rw (
                .pair(st.cmd[CMD_RW+1:CMD_RW]),
                .stored(st.tlb[g][idx].rw),
                .match(m_rw[g])
            );
            assign way_hit[g] = st.tlb[g][idx].valid &
                (st.tlb[g][idx].tag == st.cmd[31:12]) &
                m_d[g] & m_u[g] & m_rw[g]; // R3 R5
        end
    endgenerate

    tcta_cache_mem u_mem (
        .aclk(aclk),
        .port(mbus.mem)
    );

    assign mbus.we = st.mwe;
    assign mbus.addr = st.maddr;
    assign mbus.wdata = st.mwdata;

    // Merges written bytes into an old register value.
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                r[b*8 +: 8] = nw[b*8 +: 8];
            end
        end
        return r;
    endfunction

    // Attribute value stored on write; undefined pairs keep the value bit.
    function automatic logic attr_wr(input logic [1:0] pair);
        logic r;
        r = pair[1];
        if (pair == 2'b01) begin
            r = 1'b0;
        end else if (pair == 2'b10) begin
            r = 1'b1;
        end
        return r;
    endfunction

    // Victim way chosen by the three-bit pseudo-LRU tree.
    function automatic logic [1:0] victim(input logic [2:0] t);
        logic [1:0] w;
        w = t[0] ? {1'b1, t[2]} : {1'b0, t[1]};
        return w;
    endfunction

    // Points the tree away from the way just used.
    function automatic logic [2:0] touch(input logic [2:0] t,
                                         input logic [1:0] w);
        logic [2:0] r;
        r = t;
        r[0] = ~w[1];
        if (w[1]) begin
            r[2] = ~w[0];
        end else begin
            r[1] = ~w[0];
        end
        return r;
    endfunction

    always_comb begin
        logic [1:0] way;
        logic [2:0] hits;
        logic [31:0] rv;
        logic ok;
        logic [6:0] line;
        way = 2'b00;
        hits = 3'($countones(way_hit));
        rv = 32'h00000000;
        ok = 1'b1;
        line = st.cctl[CCTL_LINE +: 7];
        next_st = st;
        next_st.mwe = 1'b0;

        if (st.bvalid && s_axi_bready) begin
            next_st.bvalid = 1'b0;
        end
        if (st.rvalid && s_axi_rready) begin
            next_st.rvalid = 1'b0;
        end
        if (st.awready && s_axi_awvalid) begin
            next_st.aw_held = 1'b1;
            next_st.aw_addr = s_axi_awaddr;
        end
        if (st.wready && s_axi_wvalid) begin
            next_st.w_held = 1'b1;
            next_st.w_data = s_axi_wdata;
            next_st.w_strb = s_axi_wstrb;
        end

        // Read: only taken while no operation is running.
        if (st.arready && s_axi_arvalid) begin // R23
            case (s_axi_araddr)
                OFS_CMD: rv = st.cmd;
                OFS_DATA: rv = st.data;
                OFS_CDATA: rv = st.cdata;
                OFS_CTAG: rv = st.ctag;
                OFS_CCTL: rv = st.cctl;
                default: ok = 1'b0;
            endcase
            next_st.rdata = rv;
            next_st.rresp = ok ? RESP_OKAY : RESP_SLVERR;
            next_st.rvalid = 1'b1;
        end else if (st.aw_held && st.w_held && !st.bvalid &&
                     st.state == ST_IDLE) begin
            next_st.bresp = RESP_OKAY;
            next_st.aw_held = 1'b0;
            next_st.w_held = 1'b0;
            next_st.bvalid = 1'b1;
            case (st.aw_addr)
                OFS_CMD: begin
                    next_st.cmd = merge(st.cmd, st.w_data, st.w_strb) &
                                  CMD_MASK;
                    next_st.state = ST_TLB; // R23
                end
                OFS_DATA: begin
                    next_st.data = merge(st.data, st.w_data, st.w_strb) &
                                   DATA_MASK;
                end
                OFS_CDATA: begin
                    next_st.cdata = merge(st.cdata, st.w_data, st.w_strb);
                end
                OFS_CTAG: begin
                    next_st.ctag = merge(st.ctag, st.w_data, st.w_strb) &
                                   CTAG_MASK;
                end
                OFS_CCTL: begin
                    next_st.cctl = merge(st.cctl, st.w_data, st.w_strb) &
                                   CCTL_MASK;
                    next_st.maddr = {next_st.cctl[CCTL_SET],
                                     next_st.cctl[CCTL_LINE +: 7]}; // R22
                    case (next_st.cctl[1:0])
                        COP_WRITE: begin
                            next_st.state = ST_CWRITE; // R21
                            next_st.mwe = 1'b1;
                            for (int b = 0; b < 4; b++) begin
                                next_st.mwdata[b*8 +: 8] =
                                    st.ctag[CTAG_VAL+b] ?
                                    st.cdata[b*8 +: 8] : 8'h00; // R20
                            end
                            next_st.mwdata[35:32] =
                                st.ctag[CTAG_VAL +: 4]; // R17
                            next_st.mwdata[58:36] =
                                st.ctag[31:CTAG_TAG]; // R19
                        end
                        COP_READ: next_st.state = ST_CREAD; // R21
                        COP_FLUSH: begin
                            next_st.state = ST_FLUSH; // R21
                            next_st.mwe = 1'b1;
                            next_st.maddr = 8'h00;
                            next_st.mwdata = 59'h0;
                        end
                        default: next_st.state = ST_IDLE; // R21
                    endcase
                end
                default: next_st.bresp = RESP_SLVERR;
            endcase
        end

        case (st.state)
            ST_IDLE: begin
            end
            ST_TLB: begin
                next_st.state = ST_IDLE;
                if (st.cmd[CMD_OP]) begin // R4
                    for (int w = 0; w < SETS; w++) begin
                        if (way_hit[w]) begin
                            way = w[1:0];
                        end
                    end
                    if (hits == 3'h1) begin // R5
                        next_st.cmd[CMD_V] = 1'b1;
                        next_st.cmd[CMD_D +: 2] =
                            {st.tlb[way][idx].dirty,
                             ~st.tlb[way][idx].dirty}; // R8
                        next_st.cmd[CMD_U +: 2] =
                            {st.tlb[way][idx].user,
                             ~st.tlb[way][idx].user}; // R8
                        next_st.cmd[CMD_RW +: 2] =
                            {st.tlb[way][idx].rw,
                             ~st.tlb[way][idx].rw}; // R8
                        next_st.data[31:12] = st.tlb[way][idx].page; // R10
                        next_st.data[DAT_PCD] = st.tlb[way][idx].page_cache_disable; // R11
                        next_st.data[DAT_PWT] = st.tlb[way][idx].page_write_through; // R11
                        next_st.data[DAT_LRU +: 3] = st.plru[idx]; // R12
                        next_st.data[DAT_HIT] = 1'b1; // R13
                        next_st.data[DAT_SET +: 2] = way; // R15
                        next_st.plru[idx] = touch(st.plru[idx], way);
                    end else begin
                        next_st.data[DAT_HIT] = 1'b0; // R13
                    end
                end else begin
                    way = st.data[DAT_HIT] ? st.data[DAT_SET +: 2] :
                          victim(st.plru[idx]); // R14 R15
                    next_st.tlb[way][idx].valid = st.cmd[CMD_V]; // R7
                    next_st.tlb[way][idx].tag = st.cmd[31:12]; // R6
                    next_st.tlb[way][idx].dirty =
                        attr_wr(st.cmd[CMD_D +: 2]); // R9
                    next_st.tlb[way][idx].user =
                        attr_wr(st.cmd[CMD_U +: 2]); // R9
                    next_st.tlb[way][idx].rw =
                        attr_wr(st.cmd[CMD_RW +: 2]); // R9
                    next_st.tlb[way][idx].page = st.data[31:12]; // R6 R10
                    next_st.tlb[way][idx].page_cache_disable = st.data[DAT_PCD]; // R11
                    next_st.tlb[way][idx].page_write_through = st.data[DAT_PWT]; // R11
                    if (st.cmd[CMD_V]) begin
                        next_st.plru[idx] = touch(st.plru[idx], way);
                    end
                end
            end
            ST_CWRITE: begin
                next_st.state = ST_IDLE;
                next_st.clru[line] = ~st.cctl[CCTL_SET];
            end
            ST_CREAD: next_st.state = ST_CCAP;
            ST_CCAP: begin
                next_st.state = ST_IDLE;
                next_st.cdata = mbus.rdata[31:0]; // R18
                next_st.ctag[31:CTAG_TAG] = mbus.rdata[58:36]; // R18
                next_st.ctag[CTAG_VAL +: 4] = mbus.rdata[35:32]; // R18
                next_st.ctag[CTAG_LRU] = st.clru[line]; // R18
            end
            ST_FLUSH: begin
                if (st.maddr == 8'hff) begin
                    next_st.state = ST_IDLE;
                    next_st.clru = '0;
                end else begin
                    next_st.mwe = 1'b1; // R21
                    next_st.maddr = st.maddr + 8'h01;
                end
            end
            default: next_st.state = ST_IDLE;
        endcase

        next_st.awready = ~next_st.aw_held & ~next_st.bvalid;
        next_st.wready = ~next_st.w_held & ~next_st.bvalid;
        next_st.arready = (next_st.state == ST_IDLE) && !next_st.rvalid &&
                          !(st.arready && s_axi_arvalid);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st <= '0;
            st.state <= ST_IDLE;
            st.cmd <= REG_RESET;
            st.data <= REG_RESET;
            st.cdata <= REG_RESET;
            st.ctag <= REG_RESET;
            st.cctl <= REG_RESET;
        end else begin
            st <= next_st;
        end
    end

    assign s_axi_awready = st.awready;
    assign s_axi_wready = st.wready;
    assign s_axi_bresp = st.bresp;
    assign s_axi_bvalid = st.bvalid;
    assign s_axi_arready = st.arready;
    assign s_axi_rdata = st.rdata;
    assign s_axi_rresp = st.rresp;
    assign s_axi_rvalid = st.rvalid;
endmodule // tcta_top

// [tb/tb.sv]
/*
 * Self-checking bench for tcta_top over AXI4-Lite.
 * Assumes the register map and timing of the design package.
 */
`timescale 1ns/1ps
module tb;
import tcta_pkg::*;
typedef struct {logic [4:0] a; logic [31:0] w, e; logic [1:0] r;} tcta_row_t;
logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
logic awready, wready, bvalid, arready, rvalid;
logic [ADDR_W-1:0] awaddr, araddr;
logic [31:0] wdata, rdata, got, m;
logic [3:0] wstrb;
logic [1:0] bresp, rresp, rs;
int n_mismatch, num_checks;
tcta_row_t rows[6] = '{
    '{OFS_DATA, 32'hffffffff, 32'hffffff9c, RESP_OKAY},
    '{OFS_CDATA, 32'hffffffff, 32'hffffffff, RESP_OKAY},
    '{OFS_CTAG, 32'hfffffe78, 32'hfffffe78, RESP_OKAY},
    '{OFS_CCTL, 32'h000007f4, 32'h000007f4, RESP_OKAY},
    '{5'h14, 32'h00000001, 32'h00000000, RESP_SLVERR},
    '{5'h1c, 32'h00000001, 32'h00000000, RESP_SLVERR}};

tcta_top dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready));

initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
end

task end_sim;
    if (n_mismatch == 0 && num_checks > 0)
        $display("*** PASS ***");
    else
        $display("*** FAIL ***");
    $finish;
endtask

task chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
        n_mismatch++;
        $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
endtask

task wr(input logic [4:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    forever begin
        @(posedge aclk);
        if (awready) awvalid <= 1'b0;
        if (wready) wvalid <= 1'b0;
        if (bvalid && bready) begin
            r = bresp;
            bready <= 1'b0;
            break;
        end
        if (bvalid) bready <= 1'b1;
        if (++n > 1000) begin
            n_mismatch++;
            end_sim();
        end
    end
endtask

task rd(input logic [4:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    forever begin
        @(posedge aclk);
        if (arready) arvalid <= 1'b0;
        if (rvalid && rready) begin
            d = rdata;
            r = rresp;
            rready <= 1'b0;
            break;
        end
        if (rvalid) rready <= 1'b1;
        if (++n > 1000) begin
            n_mismatch++;
            end_sim();
        end
    end
endtask

initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
    awaddr = '0;
    araddr = '0;
    wdata = '0;
    wstrb = 4'hf;
    n_mismatch = 0;
    num_checks = 0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    for (int i = 0; i < 5; i++) begin
        rd(5'(i * 4), got, rs);
        chk(got, REG_RESET);
    end
    foreach (rows[i]) begin
        wr(rows[i].a, rows[i].w, rs);
        chk(32'(rs), 32'(rows[i].r));
        rd(rows[i].a, got, rs);
        chk(got, rows[i].e);
        chk(32'(rs), 32'(rows[i].r));
    end
    // Translation buffer write, attribute lookups, miss, invalidate.
    wr(OFS_DATA, 32'h12345c18, rs);
    wr(OFS_CMD, 32'habcdecc0, rs);
    wr(OFS_DATA, 32'h0, rs);
    for (int j = 0; j < 4; j++) begin
        wr(OFS_CMD, 32'habcde1e1 | (j << 9), rs);
        rd(OFS_DATA, got, rs);
        chk(got & 32'h10, j[1] ? 32'h10 : 32'h0);
    end
    chk(got & ~32'h380, 32'h12345c18);
    chk(got & 32'h380, 32'h200);
    rd(OFS_CMD, got, rs);
    chk(got, 32'habcdecc1);
    wr(OFS_CMD, 32'habcde761, rs);
    rd(OFS_DATA, got, rs);
    chk(got & ~32'h380, 32'h12345c08);
    wr(OFS_DATA, 32'h12345c18, rs);
    wr(OFS_CMD, 32'habcde7e0, rs);
    wr(OFS_CMD, 32'habcde7e1, rs);
    rd(OFS_DATA, got, rs);
    chk(got & 32'h10, 32'h0);
    wr(OFS_DATA, 32'h55555014, rs);
    wr(OFS_CMD, 32'h000118a0, rs);
    wr(OFS_CMD, 32'h000117e1, rs);
    rd(OFS_DATA, got, rs);
    chk(got & ~32'h380, 32'h55555014);
    // Four replacement writes into one row land in four sets.
    m = 32'h0;
    wr(OFS_DATA, 32'h0, rs);
    for (int k = 0; k < 4; k++) wr(OFS_CMD, (k << 15) | 32'h8a0, rs);
    for (int k = 0; k < 4; k++) begin
        wr(OFS_CMD, (k << 15) | 32'h7e1, rs);
        rd(OFS_DATA, got, rs);
        chk(got & 32'h10, 32'h10);
        m = m | (32'h1 << got[3:2]);
    end
    chk(m, 32'hf);
    // Cache line write, read back, partial valids, other set, flush.
    wr(OFS_CCTL, 32'h3, rs);
    wr(OFS_CTAG, 32'habcdee78, rs);
    wr(OFS_CDATA, 32'hdeadbeef, rs);
    wr(OFS_CCTL, 32'h55, rs);
    wr(OFS_CDATA, 32'h0, rs);
    wr(OFS_CTAG, 32'h0, rs);
    wr(OFS_CCTL, 32'h56, rs);
    rd(OFS_CDATA, got, rs);
    chk(got, 32'hdeadbeef);
    rd(OFS_CTAG, got, rs);
    chk(got & ~32'h80, 32'habcdee78);
    wr(OFS_CDATA, 32'h11223344, rs);
    wr(OFS_CTAG, 32'h628, rs);
    wr(OFS_CCTL, 32'h15, rs);
    wr(OFS_CCTL, 32'h16, rs);
    rd(OFS_CDATA, got, rs);
    chk(got, 32'h00220044);
    wr(OFS_CCTL, 32'h52, rs);
    rd(OFS_CDATA, got, rs);
    chk(got, 32'h0);
    wr(OFS_CCTL, 32'h53, rs);
    wr(OFS_CCTL, 32'h56, rs);
    rd(OFS_CDATA, got, rs);
    chk(got, 32'h0);
    rd(OFS_CTAG, got, rs);
    chk(got, 32'h0);
    end_sim();
end
endmodule // tb

// [tb/tcta_top_props.sv]
/*
 * Checker for the register bus timing and read masks of tcta_top.
 * Bound to tcta_top; sees only its ports, one clock domain.
 */
`timescale 1ns/1ps
module tcta_props
import tcta_pkg::*;
(
    // Clock and reset.
    input wire logic aclk,
    input wire logic aresetn,
    // Write channels.
    input wire logic [tcta_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // Read channels.
    input wire logic [tcta_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence s_rd;
        s_axi_arvalid && s_axi_arready;
    endsequence
    sequence s_wr;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    property p_rd_lat;
        s_rd |=> s_axi_rvalid;
    endproperty
    a_rd_lat: assert property (p_rd_lat) else $error("late read");
    property p_rd_hold;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("rdata moved");
    property p_b_hold;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    a_b_hold: assert property (p_b_hold) else $error("bresp moved");
    property p_ar_busy;
        s_axi_rvalid |-> !s_axi_arready;
    endproperty
    a_ar_busy: assert property (p_ar_busy) else $error("ar while busy");
    property p_w_busy;
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
    endproperty
    a_w_busy: assert property (p_w_busy) else $error("aw while busy");
    property p_wr_done;
        s_wr |-> ##[1:300] s_axi_bvalid;
    endproperty
    a_wr_done: assert property (p_wr_done) else $error("no bvalid");
    property p_bad_rd;
        s_rd ##0 (s_axi_araddr > OFS_CCTL) |=>
            s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0;
    endproperty
    a_bad_rd: assert property (p_bad_rd) else $error("bad read");
    property p_cmd_mask;
        s_rd ##0 (s_axi_araddr == OFS_CMD) |=> (s_axi_rdata & ~CMD_MASK) == 0;
    endproperty
    a_cmd_mask: assert property (p_cmd_mask) else $error("cmd bits");
    property p_dat_mask;
        s_rd ##0 (s_axi_araddr == OFS_DATA) |=>
            (s_axi_rdata & ~DATA_MASK) == 0;
    endproperty
    a_dat_mask: assert property (p_dat_mask) else $error("data bits");
endmodule // tcta_props

bind tcta_top tcta_props u_props (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready));
